// ===== core/sst_map.vh
// Timing and frame constants for the start-stop character transmitter
`ifndef SST_MAP_VH
`define SST_MAP_VH
`define SST_CLK_HZ 64'd200000000
`define SST_MIN_X10 64'd600
`define SST_OPM_X10 64'd3681
`define SST_STOP_X100 32'd142
`define SST_FRAME_X100 64'd742
`define SST_PCT 32'd100
// Standard unit: one 7.42-unit frame fills one character cycle; 64 bits avoid overflow
`define SST_UNIT_CYC ((`SST_CLK_HZ * `SST_MIN_X10 * 64'd100) / (`SST_OPM_X10 * `SST_FRAME_X100))
`define SST_DIV_STD 24'h000000
`define SST_CNT_ZERO 24'h000000
`define SST_CNT_STEP 24'h000001
`define SST_FIRST_BIT 3'h0
`define SST_BIT_STEP 3'h1
`define SST_CODE_RST 5'h00
`define SST_BUF_EMPTY 2'h0
`define SST_BUF_ONE 2'h1
`define SST_BUF_FULL 2'h2
`define SST_BUF_STEP 2'h1
`define SST_CODE_W 5
`define SST_BIT_CNT_W 3
`define SST_LAST_BIT 3'h4
`define SST_DIV_W 24
`define SST_LINE_MARK 1'b1
`define SST_LINE_SPACE 1'b0
`endif

// ===== core/sst_transmitter.v
// Start-stop five-unit character transmitter with keyboard capture
// Function
// - Key press while idle, with room in the capture buffer, starts a cycle and loads its five-bit code.
// - Captured code stays locked until the frame is fully sent.
// - Frame opens with one spacing start unit before code units.
// - Code unit is marking for a set bit, spacing for clear.
// - Five code units follow in order, first bit first.
// - Marking means closed contact, spacing means open contact.
// - After fifth code unit a marking stop element is sent.
// - After stop, cycle halts and line idles marking.
// - Idle transmitter stays stopped while start-inhibit latch is set.
// - Key held at frame end blocks new cycles until released.
// - Standard rate 368.1 frames per minute; speed scales all timing.
// - Start and code units one unit, stop 1.42 units.
`timescale 1ns/10ps
`include "sst_map.vh"
module sst_transmitter (
   input wire clk_i,
   input wire reset_i,
   input wire key_down_i,
   input wire [4:0] key_code_i,
   input wire [23:0] unit_div_i,
   input wire cap_ready_i,
   output wire cap_valid_o,
   output reg [4:0] cap_code_o,
   output reg line_mark_o,
   output reg contact_closed_o,
   output reg busy_o,
   output reg inhibit_o
);
   // Default unit length at standard speed, in clock cycles
   localparam [63:0] UNIT_STD_W = `SST_UNIT_CYC;
   localparam [63:0] STOP_STD_W = (`SST_UNIT_CYC * `SST_STOP_X100) / `SST_PCT;
   // Both standard lengths fit in the 24-bit divider width
   localparam [23:0] UNIT_STD = UNIT_STD_W[23:0];
   localparam [23:0] STOP_STD = STOP_STD_W[23:0];
   localparam [3:0] S_IDLE = 4'h1;
   localparam [3:0] S_START = 4'h2;
   localparam [3:0] S_CODE = 4'h4;
   localparam [3:0] S_STOP = 4'h8;

   // Stop element length: 1.42 of the unit, computed from the divider
   function [23:0] stop_len;
      input [23:0] unit;
      reg [31:0] prod;
      reg [31:0] quot;
      begin
         prod = {8'h00, unit} * `SST_STOP_X100;
         quot = prod / `SST_PCT;
         stop_len = quot[23:0];
      end
   endfunction

   reg key_s1_r, key_s2_r;
   reg [4:0] code_s1_r, code_s2_r;
   reg key_prev_r;
   reg [3:0] state_r, state_nxt;
   reg [4:0] shift_r;
   reg [2:0] bit_r;
   reg [23:0] cnt_r;
   reg [4:0] buf0_r, buf1_r;
   reg [1:0] buf_cnt_r;
   reg [4:0] buf0_nxt, buf1_nxt;
   reg [1:0] buf_cnt_nxt;
   wire [23:0] unit_len;
   wire [23:0] stop_cyc;
   wire unit_done;
   wire press;
   wire buf_in_ready;
   wire push;
   wire pop;
   wire code_bit;
   wire line_nxt;

   // Divider of zero falls back to standard speed
   assign unit_len = (unit_div_i == `SST_DIV_STD) ? UNIT_STD : unit_div_i;
   assign stop_cyc = (unit_div_i == `SST_DIV_STD) ? STOP_STD : stop_len(unit_div_i);
   assign press = key_s2_r & ~key_prev_r;
   assign buf_in_ready = (buf_cnt_r != `SST_BUF_FULL);
   assign unit_done = (state_r == S_STOP) ? (cnt_r >= stop_cyc - `SST_CNT_STEP)
                                          : (cnt_r >= unit_len - `SST_CNT_STEP);
   // Code bit for the next code unit: first bit after start, then one per unit
   assign code_bit = (state_r == S_START) ? shift_r[`SST_FIRST_BIT]
                   : (unit_done ? shift_r[bit_r + `SST_BIT_STEP] : shift_r[bit_r]);
   // Line level of the element that runs after the next edge
   assign line_nxt = (state_nxt == S_START) ? `SST_LINE_SPACE
                   : (state_nxt == S_CODE) ? code_bit
                   : `SST_LINE_MARK;
   // Capture only when idle, uninhibited, and buffer has room
   assign push = press & (state_r == S_IDLE) & ~inhibit_o & buf_in_ready;
   assign pop = cap_valid_o & cap_ready_i;
   assign cap_valid_o = (buf_cnt_r != `SST_BUF_EMPTY);

   // Two-flop synchronisers for the keyboard pins
   always @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         key_s1_r <= 1'b0;
         key_s2_r <= 1'b0;
         code_s1_r <= `SST_CODE_RST;
         code_s2_r <= `SST_CODE_RST;
         key_prev_r <= 1'b0;
      end else begin
         key_s1_r <= key_down_i;
         key_s2_r <= key_s1_r;
         code_s1_r <= key_code_i;
         code_s2_r <= code_s1_r;
         key_prev_r <= key_s2_r;
      end
   end

   // Next-state logic of the frame sequencer
   always @* begin
      state_nxt = state_r;
      case (state_r)
         S_IDLE: begin
            if (push) begin
               state_nxt = S_START;
            end
         end
         S_START: begin
            if (unit_done) begin
               state_nxt = S_CODE;
            end
         end
         S_CODE: begin
            if (unit_done && bit_r == `SST_LAST_BIT) begin
               state_nxt = S_STOP;
            end
         end
         S_STOP: begin
            if (unit_done) begin
               state_nxt = S_IDLE;
            end
         end
         default: begin
            state_nxt = S_IDLE;
         end
      endcase
   end

   // Sequencer, code holding stage, timing and line drive
   always @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         state_r <= S_IDLE;
         shift_r <= `SST_CODE_RST;
         bit_r <= `SST_FIRST_BIT;
         cnt_r <= `SST_CNT_ZERO;
         line_mark_o <= `SST_LINE_MARK;
         contact_closed_o <= `SST_LINE_MARK;
         busy_o <= 1'b0;
         inhibit_o <= 1'b0;
      end else begin
         state_r <= state_nxt;
         // Element timer restarts at every element boundary, also between code units
         if (state_r == S_IDLE || unit_done) begin
            cnt_r <= `SST_CNT_ZERO;
         end else begin
            cnt_r <= cnt_r + `SST_CNT_STEP;
         end
         // Code locked from start to end of frame
         if (push) begin
            shift_r <= code_s2_r;
            bit_r <= `SST_FIRST_BIT;
         end else if (state_r == S_CODE && unit_done) begin
            bit_r <= bit_r + `SST_BIT_STEP;
         end
         busy_o <= (state_nxt != S_IDLE);
         // Line level per element; the contact is closed exactly while marking
         line_mark_o <= line_nxt;
         contact_closed_o <= line_nxt;
         // Inhibit latch: set if key still held at frame end, cleared on release
         if (state_r == S_STOP && unit_done && key_s2_r) begin
            inhibit_o <= 1'b1;
         end else if (!key_s2_r) begin
            inhibit_o <= 1'b0;
         end
      end
   end

   // Next contents of the two-entry buffer; a pop moves the second entry forward
   always @* begin
      buf0_nxt = buf0_r;
      buf1_nxt = buf1_r;
      buf_cnt_nxt = buf_cnt_r;
      if (pop) begin
         buf0_nxt = buf1_r;
      end
      if (push && pop) begin
         if (buf_cnt_r == `SST_BUF_ONE) begin
            buf0_nxt = code_s2_r;
         end else begin
            buf1_nxt = code_s2_r;
         end
      end else if (push) begin
         if (buf_cnt_r == `SST_BUF_EMPTY) begin
            buf0_nxt = code_s2_r;
         end else begin
            buf1_nxt = code_s2_r;
         end
         buf_cnt_nxt = buf_cnt_r + `SST_BUF_STEP;
      end else if (pop) begin
         buf_cnt_nxt = buf_cnt_r - `SST_BUF_STEP;
      end
   end

   // Buffer storage; the output mirrors the head so data is valid with valid
   always @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         buf0_r <= `SST_CODE_RST;
         buf1_r <= `SST_CODE_RST;
         buf_cnt_r <= `SST_BUF_EMPTY;
         cap_code_o <= `SST_CODE_RST;
      end else begin
         buf0_r <= buf0_nxt;
         buf1_r <= buf1_nxt;
         buf_cnt_r <= buf_cnt_nxt;
         cap_code_o <= buf0_nxt;
      end
   end
endmodule // sst_transmitter

// ===== verification/sst_transmitter_props.sv
// Port checker for the start-stop transmitter
`timescale 1ns/10ps
module sst_transmitter_props (
   input wire clk_i,
   input wire reset_i,
   input wire key_down_i,
   input wire [23:0] unit_div_i,
   input wire cap_ready_i,
   input wire cap_valid_o,
   input wire line_mark_o,
   input wire contact_closed_o,
   input wire busy_o,
   input wire inhibit_o
);
   // One clock domain
   default clocking @(posedge clk_i); endclocking
   default disable iff (reset_i);
   // Busy cycles of the running frame against 6 units plus a 1.42-unit stop
   reg [31:0] busy_len_r;
   wire [31:0] frame_cyc;
   assign frame_cyc = unit_div_i * 32'd6 + (unit_div_i * 32'd142) / 32'd100;
   always @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         busy_len_r <= 32'h00000000;
      end else if (busy_o) begin
         busy_len_r <= busy_len_r + 32'h00000001;
      end else begin
         busy_len_r <= 32'h00000000;
      end
   end
   a_contact_line: assert property (contact_closed_o == line_mark_o)
      else $error("contact");
   a_idle_mark: assert property (!busy_o |-> line_mark_o)
      else $error("idle line");
   a_start_space: assert property ($rose(busy_o) |-> !line_mark_o)
      else $error("start unit");
   a_inhibit_hold: assert property (inhibit_o |=> !$rose(busy_o))
      else $error("inhibit");
   a_release_clear: assert property (!key_down_i [*4] |-> !inhibit_o)
      else $error("release");
   a_frame_len: assert property ($fell(busy_o) && unit_div_i != 24'h000000 |-> busy_len_r == frame_cyc)
      else $error("frame length");
   a_stop_mark: assert property ($fell(busy_o) |-> $past(line_mark_o))
      else $error("stop unit");
   a_buf_hold: assert property (cap_valid_o && !cap_ready_i |=> cap_valid_o)
      else $error("buffer");
   // Main scenarios reached
   c_frame: cover property ($rose(busy_o));
   c_inhibit: cover property ($rose(inhibit_o));
   c_stall: cover property (cap_valid_o && !cap_ready_i);
endmodule // sst_transmitter_props
bind sst_transmitter sst_transmitter_props sst_transmitter_props_inst (.clk_i, .reset_i,
   .key_down_i, .unit_div_i, .cap_ready_i, .cap_valid_o, .line_mark_o, .contact_closed_o, .busy_o,
   .inhibit_o);

// ===== verification/sst_rx_model.sv
// Behavioural remote receiver that decodes the line
`timescale 1ns/10ps
module sst_rx_model #(
   parameter integer UNIT = 10
) (
   input wire clk_i,
   input wire line_i,
   output reg [4:0] code_o,
   output reg [7:0] count_o,
   output reg stop_ok_o
);
   integer i;
   reg [4:0] bits;
   initial begin
      code_o = 5'h00;
      count_o = 8'h00;
      stop_ok_o = 1'b1;
   end
   // Start on the space edge, sample each unit at its middle
   always begin
      @(negedge line_i);
      repeat (UNIT / 2) @(posedge clk_i);
      for (i = 0; i < 5; i = i + 1) begin
         repeat (UNIT) @(posedge clk_i);
         bits[i] = line_i;
      end
      repeat (UNIT) @(posedge clk_i);
      stop_ok_o = line_i;
      code_o = bits;
      count_o = count_o + 8'h01;
   end
endmodule // sst_rx_model

// ===== verification/test_start_stop_char_transmitter.sv
// Bench for the start-stop transmitter
`timescale 1ns/10ps
`define CHK(a, b, m) begin n_checks++; if ((a) !== (b)) begin bad_count++; \
   $display("[FAIL] %0t %s", $time, m); end end
module test_start_stop_char_transmitter;
   reg clk_i, reset_i, key_down_i, cap_ready_i;
   reg [4:0] key_code_i;
   reg [23:0] unit_div_i;
   wire cap_valid_o, line_mark_o, contact_closed_o, busy_o, inhibit_o, stop_ok;
   wire [4:0] cap_code_o, rx_code;
   wire [7:0] rx_count;
   integer bad_count = 0, n_checks = 0, cycles = 0, k;
   sst_transmitter sst_transmitter_inst (.clk_i, .reset_i, .key_down_i, .key_code_i,
      .unit_div_i, .cap_ready_i, .cap_valid_o, .cap_code_o, .line_mark_o,
      .contact_closed_o, .busy_o, .inhibit_o);
   sst_rx_model #(.UNIT(10)) sst_rx_model_inst (.clk_i, .line_i(line_mark_o),
      .code_o(rx_code), .count_o(rx_count), .stop_ok_o(stop_ok));
   // Clock and hang guard
   initial begin clk_i = 1'b0; forever #2.5 clk_i = ~clk_i; end
   always @(posedge clk_i) begin
      cycles++;
      if (cycles == 50000) begin bad_count++; tally_and_finish; end
   end
   task tally_and_finish;
      begin
         $display("checks %0d mismatches %0d", n_checks, bad_count);
         if (bad_count == 0 && n_checks > 0) $display("No errors found");
         else $display("Errors were found");
         $finish;
      end
   endtask
   // Key held for h cycles, then bounded wait for the frame end
   task press(input [4:0] c, input integer h);
      begin key_code_i = c; key_down_i = 1'b1; repeat (h) @(negedge clk_i); key_down_i = 1'b0;
         for (k = 0; k < 200 && busy_o !== 1'b0; k++) @(negedge clk_i);
         repeat (8) @(negedge clk_i); end
   endtask
   task send(input [4:0] c);
      begin press(c, 6); `CHK(rx_code, c, "code") `CHK(stop_ok, 1'b1, "stop") end
   endtask
   // Stalled consumer: two codes kept, third refused, then drained
   task t_buffer;
      begin cap_ready_i = 1'b0; send(5'h15); send(5'h0a); press(5'h1f, 6);
         `CHK(rx_count, 8'h02, "full")
         `CHK(cap_code_o, 5'h15, "head")
         cap_ready_i = 1'b1; @(negedge clk_i); cap_ready_i = 1'b0; repeat (2) @(negedge clk_i);
         `CHK(cap_code_o, 5'h0a, "next")
         cap_ready_i = 1'b1; repeat (2) @(negedge clk_i); `CHK(cap_valid_o, 1'b0, "empty") end
   endtask
   // Second key in mid-frame changes nothing
   task t_lock;
      begin key_code_i = 5'h11; key_down_i = 1'b1; repeat (30) @(negedge clk_i);
         key_down_i = 1'b0; repeat (4) @(negedge clk_i); press(5'h0e, 6);
         `CHK(rx_code, 5'h11, "lock")
         `CHK(rx_count, 8'h03, "queued") end
   endtask
   // Held key blocks frames until released
   task t_hold;
      begin key_code_i = 5'h07; key_down_i = 1'b1; repeat (120) @(negedge clk_i);
         `CHK(inhibit_o, 1'b1, "inhibit")
         `CHK(rx_count, 8'h04, "one frame")
         `CHK(line_mark_o, 1'b1, "idle")
         `CHK(contact_closed_o, 1'b1, "contact")
         key_down_i = 1'b0; repeat (6) @(negedge clk_i); `CHK(inhibit_o, 1'b0, "clear")
         send(5'h07); `CHK(rx_count, 8'h05, "again") end
   endtask
   // Standard speed keeps the start unit far beyond a long wait; a mid-run reset ends it
   task t_std;
      begin unit_div_i = 24'h000000; key_code_i = 5'h1f; key_down_i = 1'b1;
         repeat (6) @(negedge clk_i); key_down_i = 1'b0; repeat (45000) @(negedge clk_i);
         `CHK(busy_o, 1'b1, "std busy")
         `CHK(line_mark_o, 1'b0, "std start")
         reset_i = 1'b1; @(negedge clk_i); reset_i = 1'b0; unit_div_i = 24'h00000a;
         `CHK(busy_o, 1'b0, "reset busy")
         `CHK(line_mark_o, 1'b1, "reset line")
         send(5'h19); `CHK(rx_count, 8'h07, "after reset") end
   endtask
   initial begin
      reset_i = 1'b1; key_down_i = 1'b0; key_code_i = 5'h00; cap_ready_i = 1'b1;
      unit_div_i = 24'h00000a;
      repeat (10) @(negedge clk_i); reset_i = 1'b0;
      t_buffer; t_lock; t_hold; t_std; tally_and_finish;
   end
endmodule // test_start_stop_char_transmitter
